// ---- verilog/gwrd_decoder.sv ----
// gwrd_decoder.sv: acyclic write record decoder for a fieldbus gateway
// assumes an avalon-mm master on mclk_in; sdo answer strobe arrives from the can side
//
// Function
// - sdo record: node byte0, index bytes1-2, sub-index byte3, type byte4, payload
// - sdo record length varies per object, five up to 2051 bytes
// - two-byte timeout record carries unsigned 16-bit sdo timeout in ms
// - wait for sdo answer no longer than configured timeout
// - timeout record applies to node of the sending slot
// - new timeout and heartbeat stay pending until manager reset
// - start record commands node 0..127 to operational
// - node zero broadcasts start, stop and pre-operational
// - stop record commands node or all nodes to stopped
// - pre-operational record commands node or all nodes to pre-operational
// - reset-node record resets node 1..127; zero refused
// - reset-communication record resets node state machine; zero refused
// - after start-up all nodes go operational without a record
// - four-byte initialize record selects new can bit-rate code
// - applying a bit-rate code restarts the network manager
// - bit-rate codes 0..8 map 1000 down to 10 kbit/s
// - heartbeat record ignores byte0, takes bytes1-2 as period
// - unanswered sdo within timeout reports protocol-timeout abort
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "gwrd_map.svh"

module gwrd_decoder
  import gwrd_pkg::*;
#(
  parameter int MS_CYCLES = `GWRD_MS_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // sdo side towards can nodes
  input wire logic sdo_answer_in,
  output logic sdo_req_out,
  output logic [7:0] sdo_node_out,
  output logic [15:0] sdo_index_out,
  output logic [7:0] sdo_subindex_out,
  output logic [7:0] sdo_type_out,
  output logic [11:0] sdo_len_out,
  output logic sdo_byte_valid_out,
  output logic [7:0] sdo_byte_out,
  // nmt commands
  output logic nmt_valid_out,
  output logic [7:0] nmt_cmd_out,
  output logic [7:0] nmt_node_out,
  // manager settings
  output logic mgr_restart_out,
  output logic [3:0] bitrate_code_out,
  output logic [15:0] heartbeat_period_field_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [15:0] rate_kbps(input logic [3:0] code);
    case (code)
      4'h0: rate_kbps = 16'd1000;
      4'h1: rate_kbps = 16'd800;
      4'h2: rate_kbps = 16'd500;
      4'h3: rate_kbps = 16'd250;
      4'h4: rate_kbps = 16'd125;
      4'h5: rate_kbps = 16'd100;
      4'h6: rate_kbps = 16'd50;
      4'h7: rate_kbps = 16'd20;
      4'h8: rate_kbps = 16'd10;
      default: rate_kbps = 16'd0;
    endcase
  endfunction : rate_kbps

  function automatic logic node_ok(input logic [7:0] n, input logic zero_ok);
    return (n <= `GWRD_NODE_MAX) && (zero_ok || (n != `GWRD_NODE_ALL));
  endfunction : node_ok

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the access completes
  logic [31:0] rec_index;
  logic [31:0] rec_len;
  logic [31:0] rec_slot;
  logic [31:0] rec_hdr;
  logic [31:0] rec_ext;
  logic wr_fire;
  logic [31:0] next_readdata;
  gwrd_result_t result;
  gwrd_sdo_state_t sdo_state;
  logic abort_flag;
  logic [31:0] abort_code;

  assign wr_fire = avs_write_in && !avs_waitrequest_out;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always_comb begin
    case (avs_address_in)
      `GWRD_REC_INDEX: next_readdata = rec_index;
      `GWRD_REC_LEN: next_readdata = rec_len;
      `GWRD_REC_SLOT: next_readdata = rec_slot;
      `GWRD_REC_HDR: next_readdata = rec_hdr;
      `GWRD_REC_EXT: next_readdata = rec_ext;
      `GWRD_STATUS: next_readdata = {26'h0, abort_flag, sdo_state, result};
      `GWRD_ABORT: next_readdata = abort_code;
      `GWRD_BITRATE: next_readdata = {rate_kbps(bitrate_code_out), 12'h000, bitrate_code_out};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // staging registers, masked to field width
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rec_index <= 32'h0000_0000;
      rec_len <= 32'h0000_0000;
      rec_slot <= 32'h0000_0000;
      rec_hdr <= 32'h0000_0000;
      rec_ext <= 32'h0000_0000;
    end else if (wr_fire) begin
      case (avs_address_in)
        `GWRD_REC_INDEX: rec_index <= be_merge(rec_index, avs_writedata_in, avs_byteenable_in)
                                      & 32'h0000_FFFF;
        `GWRD_REC_LEN: rec_len <= be_merge(rec_len, avs_writedata_in, avs_byteenable_in)
                                  & 32'h0000_0FFF;
        `GWRD_REC_SLOT: rec_slot <= be_merge(rec_slot, avs_writedata_in, avs_byteenable_in)
                                    & 32'h0000_00FF;
        `GWRD_REC_HDR: rec_hdr <= be_merge(rec_hdr, avs_writedata_in, avs_byteenable_in);
        `GWRD_REC_EXT: rec_ext <= be_merge(rec_ext, avs_writedata_in, avs_byteenable_in)
                                  & 32'h0000_00FF;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record decode
  logic commit;
  logic mgr_reset_req;
  logic payload_wr;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [11:0] len;
  logic [15:0] idx;
  gwrd_result_t next_result;
  logic is_nmt;
  gwrd_nmt_t nmt_kind;
  logic zero_ok;
  logic [11:0] want_len;

  assign commit = wr_fire && (avs_address_in == `GWRD_CMD) && avs_byteenable_in[0]
                  && avs_writedata_in[`GWRD_CMD_COMMIT];
  assign mgr_reset_req = wr_fire && (avs_address_in == `GWRD_CMD) && avs_byteenable_in[0]
                         && avs_writedata_in[`GWRD_CMD_MGR_RESET];
  assign payload_wr = wr_fire && (avs_address_in == `GWRD_PAYLOAD) && avs_byteenable_in[0];
  assign b0 = rec_hdr[7:0];
  assign b1 = rec_hdr[15:8];
  assign b2 = rec_hdr[23:16];
  assign b3 = rec_hdr[31:24];
  assign len = rec_len[11:0];
  assign idx = rec_index[15:0];

  // one handler per index
  always_comb begin
    is_nmt = 1'b1;
    nmt_kind = GWRD_NMT_START;
    zero_ok = 1'b1;
    want_len = `GWRD_NMT_LEN;
    case (idx)
      `GWRD_IDX_START: nmt_kind = GWRD_NMT_START;
      `GWRD_IDX_STOP: nmt_kind = GWRD_NMT_STOP;
      `GWRD_IDX_PREOP: nmt_kind = GWRD_NMT_PREOP;
      `GWRD_IDX_RST_NODE: begin
        nmt_kind = GWRD_NMT_RST_NODE;
        zero_ok = 1'b0;
      end
      `GWRD_IDX_RST_COMM: begin
        nmt_kind = GWRD_NMT_RST_COMM;
        zero_ok = 1'b0;
      end
      `GWRD_IDX_SDO_TMO: begin
        is_nmt = 1'b0;
        want_len = `GWRD_TMO_LEN;
      end
      `GWRD_IDX_INIT: begin
        is_nmt = 1'b0;
        want_len = `GWRD_INIT_LEN;
      end
      `GWRD_IDX_HBEAT: begin
        is_nmt = 1'b0;
        want_len = `GWRD_HBEAT_LEN;
      end
      default: is_nmt = 1'b0;
    endcase
  end

  always_comb begin
    next_result = GWRD_RES_OK;
    if (idx == `GWRD_IDX_SDO_DL) begin
      if (len < `GWRD_SDO_HDR_LEN || len > `GWRD_SDO_MAX_LEN) begin
        next_result = GWRD_RES_BAD_LEN;
      end else if (!node_ok(b0, 1'b0)) begin
        next_result = GWRD_RES_BAD_NODE;
      end else if (sdo_state != GWRD_IDLE) begin
        next_result = GWRD_RES_BUSY;
      end
    end else if (is_nmt || idx == `GWRD_IDX_SDO_TMO || idx == `GWRD_IDX_INIT
                 || idx == `GWRD_IDX_HBEAT) begin
      if (len != want_len) begin
        next_result = GWRD_RES_BAD_LEN;
      end else if (is_nmt && !node_ok(b0, zero_ok)) begin
        next_result = GWRD_RES_BAD_NODE;
      end else if (idx == `GWRD_IDX_SDO_TMO && !node_ok(rec_slot[7:0], 1'b0)) begin
        next_result = GWRD_RES_BAD_NODE;
      end else if (idx == `GWRD_IDX_INIT && {b0, b1, b2, b3} > `GWRD_RATE_MAX) begin
        next_result = GWRD_RES_BAD_LEN;
      end
    end else begin
      next_result = GWRD_RES_BAD_INDEX;
    end
  end

  logic ok;
  assign ok = commit && (next_result == GWRD_RES_OK);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result <= GWRD_RES_NONE;
    end else if (commit) begin
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manager settings: pending copies take effect on restart
  logic [15:0] tmo_pend [128];
  logic [15:0] tmo_eff [128];
  logic [15:0] hb_pend;
  logic restart;

  assign restart = mgr_reset_req || (ok && idx == `GWRD_IDX_INIT);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 128; i++) begin
        tmo_pend[i] <= `GWRD_TMO_RST;
        tmo_eff[i] <= `GWRD_TMO_RST;
      end
      hb_pend <= `GWRD_HBEAT_RST;
      heartbeat_period_field_out <= `GWRD_HBEAT_RST;
      bitrate_code_out <= `GWRD_RATE_RST;
    end else begin
      if (ok && idx == `GWRD_IDX_SDO_TMO) begin
        tmo_pend[rec_slot[6:0]] <= {b0, b1};
      end
      if (ok && idx == `GWRD_IDX_HBEAT) begin
        hb_pend <= {b1, b2};
      end
      if (ok && idx == `GWRD_IDX_INIT) begin
        bitrate_code_out <= b3[3:0];
      end
      if (restart) begin
        tmo_eff <= tmo_pend;
        heartbeat_period_field_out <= hb_pend;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mgr_restart_out <= 1'b0;
    end else begin
      mgr_restart_out <= restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nmt commands; boot start deferred past a same-cycle record command
  logic boot_pending;
  logic nmt_fire;

  assign nmt_fire = ok && is_nmt;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_pending <= 1'b1;
      nmt_valid_out <= 1'b0;
      nmt_cmd_out <= 8'h00;
      nmt_node_out <= 8'h00;
    end else begin
      nmt_valid_out <= nmt_fire || boot_pending;
      if (nmt_fire) begin
        nmt_cmd_out <= nmt_kind;
        nmt_node_out <= b0;
      end else if (boot_pending) begin
        nmt_cmd_out <= GWRD_NMT_START;
        nmt_node_out <= `GWRD_NODE_ALL;
      end
      if (restart) begin
        boot_pending <= 1'b1;
      end else if (!nmt_fire) begin
        boot_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sdo download: request, payload bytes, then answer wait
  logic ans_meta;
  logic ans_sync;
  logic [11:0] payload_left;
  logic [31:0] ms_div;
  logic [16:0] ms_count;
  logic timed_out;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ans_meta <= 1'b0;
      ans_sync <= 1'b0;
    end else begin
      ans_meta <= sdo_answer_in;
      ans_sync <= ans_meta;
    end
  end

  assign timed_out = (ms_count >= {1'b0, tmo_eff[sdo_node_out[6:0]]});

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_state <= GWRD_IDLE;
      sdo_req_out <= 1'b0;
      sdo_node_out <= 8'h00;
      sdo_index_out <= 16'h0000;
      sdo_subindex_out <= 8'h00;
      sdo_type_out <= 8'h00;
      sdo_len_out <= 12'h000;
      sdo_byte_valid_out <= 1'b0;
      sdo_byte_out <= 8'h00;
      payload_left <= 12'h000;
      ms_div <= 32'h0000_0000;
      ms_count <= 17'h00000;
    end else begin
      sdo_req_out <= 1'b0;
      sdo_byte_valid_out <= 1'b0;
      case (sdo_state)
        GWRD_IDLE: begin
          if (ok && idx == `GWRD_IDX_SDO_DL) begin
            sdo_req_out <= 1'b1;
            sdo_node_out <= b0;
            sdo_index_out <= {b1, b2};
            sdo_subindex_out <= b3;
            sdo_type_out <= rec_ext[7:0];
            sdo_len_out <= len - `GWRD_SDO_HDR_LEN;
            payload_left <= len - `GWRD_SDO_HDR_LEN;
            ms_div <= 32'h0000_0000;
            ms_count <= 17'h00000;
            sdo_state <= (len == `GWRD_SDO_HDR_LEN) ? GWRD_WAIT : GWRD_LOAD;
          end
        end
        GWRD_LOAD: begin
          if (payload_wr) begin
            sdo_byte_valid_out <= 1'b1;
            sdo_byte_out <= avs_writedata_in[7:0];
            payload_left <= payload_left - 12'h001;
            if (payload_left == 12'h001) begin
              sdo_state <= GWRD_WAIT;
            end
          end
        end
        GWRD_WAIT: begin
          if (ans_sync || timed_out) begin
            sdo_state <= GWRD_IDLE;
          end else if (ms_div == MS_CYCLES - 1) begin
            ms_div <= 32'h0000_0000;
            ms_count <= ms_count + 17'h00001;
          end else begin
            ms_div <= ms_div + 32'h0000_0001;
          end
        end
        default: sdo_state <= GWRD_IDLE;
      endcase
    end
  end

  // abort flag: a timeout wins over a same-cycle clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      abort_flag <= 1'b0;
      abort_code <= 32'h0000_0000;
    end else if (sdo_state == GWRD_WAIT && !ans_sync && timed_out) begin
      abort_flag <= 1'b1;
      abort_code <= `GWRD_ABORT_TIMEOUT;
    end else if (wr_fire && avs_address_in == `GWRD_CMD && avs_byteenable_in[0]
                 && avs_writedata_in[`GWRD_CMD_CLR_ABORT]) begin
      abort_flag <= 1'b0;
      abort_code <= 32'h0000_0000;
    end
  end

endmodule : gwrd_decoder

`default_nettype wire

// ---- verilog/gwrd_map.svh ----
// gwrd_map.svh: offsets, fields, reset values and timing counts
// assumes inclusion by the decoder and bench; no code
`ifndef GWRD_MAP_SVH
`define GWRD_MAP_SVH

// avalon byte addresses
`define GWRD_REC_INDEX 6'h00
`define GWRD_REC_LEN 6'h04
`define GWRD_REC_SLOT 6'h08
`define GWRD_REC_HDR 6'h0C
`define GWRD_REC_EXT 6'h10
`define GWRD_CMD 6'h14
`define GWRD_PAYLOAD 6'h18
`define GWRD_STATUS 6'h1C
`define GWRD_ABORT 6'h20
`define GWRD_BITRATE 6'h24

// command register bits
`define GWRD_CMD_COMMIT 0
`define GWRD_CMD_MGR_RESET 1
`define GWRD_CMD_CLR_ABORT 2

// record indexes
`define GWRD_IDX_SDO_DL 16'hB713
`define GWRD_IDX_SDO_TMO 16'hB715
`define GWRD_IDX_START 16'hB731
`define GWRD_IDX_STOP 16'hB732
`define GWRD_IDX_PREOP 16'hB733
`define GWRD_IDX_RST_NODE 16'hB734
`define GWRD_IDX_RST_COMM 16'hB735
`define GWRD_IDX_INIT 16'hB751
`define GWRD_IDX_HBEAT 16'hB754

// record lengths and ranges
`define GWRD_SDO_HDR_LEN 12'h005
`define GWRD_SDO_MAX_LEN 12'h803
`define GWRD_TMO_LEN 12'h002
`define GWRD_NMT_LEN 12'h001
`define GWRD_INIT_LEN 12'h004
`define GWRD_HBEAT_LEN 12'h003
`define GWRD_NODE_MAX 8'h7F
`define GWRD_NODE_ALL 8'h00
`define GWRD_RATE_MAX 32'h0000_0008

// reset values and timeout abort code
`define GWRD_TMO_RST 16'h03E8
`define GWRD_HBEAT_RST 16'h0000
`define GWRD_RATE_RST 4'h2
`define GWRD_ABORT_TIMEOUT 32'h0504_0000

// timing
`define GWRD_CLK_HZ 20000000
`define GWRD_MS_PER_S 1000
`define GWRD_MS_CYCLES (`GWRD_CLK_HZ / `GWRD_MS_PER_S)

`endif

// ---- verilog/gwrd_pkg.sv ----
// gwrd_pkg.sv: types shared by the write record decoder
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package gwrd_pkg;

  typedef enum logic [1:0] {
    GWRD_IDLE = 2'b00,
    GWRD_LOAD = 2'b01,
    GWRD_WAIT = 2'b10
  } gwrd_sdo_state_t;

  typedef enum logic [2:0] {
    GWRD_RES_NONE = 3'b000,
    GWRD_RES_OK = 3'b001,
    GWRD_RES_BAD_INDEX = 3'b010,
    GWRD_RES_BAD_LEN = 3'b011,
    GWRD_RES_BAD_NODE = 3'b100,
    GWRD_RES_BUSY = 3'b101
  } gwrd_result_t;

  typedef enum logic [7:0] {
    GWRD_NMT_START = 8'h01,
    GWRD_NMT_STOP = 8'h02,
    GWRD_NMT_PREOP = 8'h80,
    GWRD_NMT_RST_NODE = 8'h81,
    GWRD_NMT_RST_COMM = 8'h82
  } gwrd_nmt_t;

endpackage : gwrd_pkg

`default_nettype wire

// ---- dv/gwrd_decoder_props.sv ----
// gwrd_decoder_props.sv: port properties of the write record decoder
// assumes bind onto gwrd_decoder, one clock, async active-high reset
`timescale 1ns/10ps
`default_nettype none
module gwrd_decoder_props
  import gwrd_pkg::*;
#(
  parameter int MS_CYCLES = 20000
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // sdo
  input wire logic sdo_req_out,
  input wire logic [7:0] sdo_node_out,
  input wire logic [11:0] sdo_len_out,
  // nmt and manager
  input wire logic nmt_valid_out,
  input wire logic [7:0] nmt_cmd_out,
  input wire logic [7:0] nmt_node_out,
  input wire logic mgr_restart_out,
  input wire logic [3:0] bitrate_code_out,
  input wire logic [15:0] heartbeat_period_field_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_bus_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus not answered");
  property p_rate_range;
    bitrate_code_out <= 4'h8;
  endproperty
  a_rate_range: assert property (p_rate_range)
    else $error("bad rate code");
  property p_rate_change;
    $changed(bitrate_code_out) |-> mgr_restart_out;
  endproperty
  a_rate_change: assert property (p_rate_change)
    else $error("rate changed without restart");
  property p_hb_pending;
    $changed(heartbeat_period_field_out) |-> mgr_restart_out;
  endproperty
  a_hb_pending: assert property (p_hb_pending)
    else $error("heartbeat changed without restart");
  property p_restart_boot;
    mgr_restart_out |-> ##[1:4] (nmt_valid_out && nmt_cmd_out == GWRD_NMT_START && nmt_node_out == 8'h00);
  endproperty
  a_restart_boot: assert property (p_restart_boot)
    else $error("no boot start");
  property p_nmt_node;
    nmt_valid_out |-> nmt_node_out <= 8'h7F;
  endproperty
  a_nmt_node: assert property (p_nmt_node)
    else $error("bad nmt node");
  property p_reset_node;
    nmt_valid_out && nmt_cmd_out inside {GWRD_NMT_RST_NODE, GWRD_NMT_RST_COMM} |-> nmt_node_out != 8'h00;
  endproperty
  a_reset_node: assert property (p_reset_node)
    else $error("reset command broadcast");
  property p_nmt_cmd;
    nmt_valid_out |-> nmt_cmd_out inside {8'h01, 8'h02, 8'h80, 8'h81, 8'h82};
  endproperty
  a_nmt_cmd: assert property (p_nmt_cmd)
    else $error("bad nmt command");
  property p_sdo_fields;
    sdo_req_out |-> sdo_node_out inside {[8'h01:8'h7F]} && sdo_len_out <= 12'h7FE;
  endproperty
  a_sdo_fields: assert property (p_sdo_fields)
    else $error("bad sdo request");
  c_restart: cover property (mgr_restart_out ##[1:4] nmt_valid_out);
  c_sdo: cover property (sdo_req_out);
  c_bcast: cover property (nmt_valid_out && nmt_node_out == 8'h00 && nmt_cmd_out == 8'h02);
endmodule : gwrd_decoder_props
bind gwrd_decoder gwrd_decoder_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .mclk_in, .rst_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out, .sdo_req_out,
  .sdo_node_out, .sdo_len_out, .nmt_valid_out, .nmt_cmd_out, .nmt_node_out,
  .mgr_restart_out, .bitrate_code_out, .heartbeat_period_field_out
);
`default_nettype wire

// ---- dv/gwrd_can_node_model.sv ----
// gwrd_can_node_model.sv: can node answering sdo downloads
// assumes the decoder's sdo strobes; answers after its last payload byte
`timescale 1ns/10ps
`default_nettype none
module gwrd_can_node_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // decoder sdo side
  input wire logic sdo_req_in,
  input wire logic [11:0] sdo_len_in,
  input wire logic sdo_byte_valid_in,
  // bench control, silent means never answer
  input wire logic silent_in,
  input wire logic [7:0] delay_in,
  // answer strobe
  output logic sdo_answer_out
);
  int left;
  int wait_cnt;
  int hold;
  logic armed;
  // held 3 clocks so the 2-stage sync cannot miss it
  assign sdo_answer_out = (hold != 0);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      left <= 0;
      wait_cnt <= 0;
      hold <= 0;
      armed <= 1'b0;
    end else begin
      if (hold != 0) hold <= hold - 1;
      if (sdo_req_in) begin
        left <= int'(sdo_len_in);
        wait_cnt <= int'(delay_in);
        armed <= !silent_in;
      end else if (sdo_byte_valid_in && left != 0) begin
        left <= left - 1;
      end else if (armed && left == 0) begin
        if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
        else begin
          armed <= 1'b0;
          hold <= 3;
        end
      end
    end
  end
endmodule : gwrd_can_node_model
`default_nettype wire

// ---- dv/gwrd_decoder_test.sv ----
// gwrd_decoder_test.sv: self-checking decoder bench
// assumes decoder, package, checker and node model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "gwrd_map.svh"
module gwrd_decoder_test;
  localparam int MSC = 8;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, sdo_answer_in, sdo_req_out, sdo_byte_valid_out;
  logic nmt_valid_out, mgr_restart_out, silent = 1'b0;
  logic [7:0] sdo_node_out, sdo_subindex_out, sdo_type_out, sdo_byte_out;
  logic [7:0] nmt_cmd_out, nmt_node_out;
  logic [15:0] sdo_index_out, heartbeat_period_field_out;
  logic [11:0] sdo_len_out;
  logic [3:0] bitrate_code_out;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 14059;
  int restarts = 0;
  logic [15:0] nmtq[$];
  logic [7:0] byteq[$];
  gwrd_decoder #(.MS_CYCLES(MSC)) u_dut (
    .mclk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_byteenable_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .sdo_answer_in, .sdo_req_out,
    .sdo_node_out, .sdo_index_out, .sdo_subindex_out, .sdo_type_out, .sdo_len_out,
    .sdo_byte_valid_out, .sdo_byte_out, .nmt_valid_out, .nmt_cmd_out, .nmt_node_out,
    .mgr_restart_out, .bitrate_code_out, .heartbeat_period_field_out
  );
  gwrd_can_node_model u_node (
    .mclk_in, .rst_in, .sdo_req_in(sdo_req_out), .sdo_len_in(sdo_len_out),
    .sdo_byte_valid_in(sdo_byte_valid_out), .silent_in(silent), .delay_in(8'h04),
    .sdo_answer_out(sdo_answer_in)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (nmt_valid_out === 1'b1) nmtq.push_back({nmt_cmd_out, nmt_node_out});
    if (sdo_byte_valid_out === 1'b1) byteq.push_back(sdo_byte_out);
    if (mgr_restart_out === 1'b1) restarts++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrr
  task automatic rdr(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rdr
  task automatic rec(input logic [15:0] idx, input logic [11:0] len, input logic [31:0] hdr,
                     input logic [7:0] ext);
    wrr(`GWRD_REC_INDEX, {16'h0000, idx});
    wrr(`GWRD_REC_LEN, {20'h00000, len});
    wrr(`GWRD_REC_HDR, hdr);
    wrr(`GWRD_REC_EXT, {24'h000000, ext});
    wrr(`GWRD_CMD, 32'h0000_0001);
  endtask : rec
  task automatic status(input logic [2:0] res);
    logic [31:0] q;
    rdr(`GWRD_STATUS, q);
    chk({29'h0, q[2:0]}, {29'h0, res});
  endtask : status
  task automatic nmt_exp(input bit ok, input logic [15:0] v);
    repeat (5) @(posedge mclk_in);
    chk(32'(nmtq.size()), 32'(ok));
    if (ok && nmtq.size() > 0) chk({16'h0, nmtq[0]}, {16'h0, v});
    nmtq.delete();
  endtask : nmt_exp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    give_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] node, cmds[5];
    logic [15:0] hbv, hb_exp;
    logic [3:0] rate_exp;
    logic [7:0] pay[$];
    int kbps[9];
    int i, k;
    bit ok;
    cmds = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82};
    kbps = '{1000, 800, 500, 250, 125, 100, 50, 20, 10};
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    nmt_exp(1'b1, 16'h0100);
    hb_exp = 16'h0000;
    rate_exp = 4'h2;
    for (i = 0; i < 5; i++) begin
      for (k = 0; k < 4; k++) begin
        node = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : (k == 2) ? 8'h80 : {1'b0, 7'($random(seed))};
        ok = node <= 8'h7F && !(i >= 3 && node == 8'h00);
        rec(16'hB731 + 16'(i), 12'h001, {24'h000000, node}, 8'h00);
        nmt_exp(ok, {cmds[i], node});
        status(ok ? 3'h1 : 3'h4);
      end
    end
    rec(`GWRD_IDX_STOP, 12'h002, 32'h0000_0003, 8'h00);
    nmt_exp(1'b0, 16'h0000);
    status(3'h3);
    rec(16'hB736, 12'h001, 32'h0000_0003, 8'h00);
    status(3'h2);
    $display("nmt test done");
    // nodes assumed already at each new rate
    for (i = 0; i < 10; i++) begin
      hbv = 16'($random(seed));
      rec(`GWRD_IDX_HBEAT, 12'h003, {8'h00, hbv[7:0], hbv[15:8], 8'h00}, 8'h00);
      chk({16'h0, heartbeat_period_field_out}, {16'h0, hb_exp});
      ok = i <= 8;
      k = restarts;
      rec(`GWRD_IDX_INIT, 12'h004, {8'(i), 24'h000000}, 8'h00);
      nmt_exp(ok, 16'h0100);
      if (ok) {hb_exp, rate_exp} = {hbv, 4'(i)};
      chk(32'(restarts - k), 32'(ok));
      chk({16'h0, heartbeat_period_field_out}, {16'h0, hb_exp});
      rdr(`GWRD_BITRATE, q);
      chk(q, {16'(kbps[rate_exp]), 12'h000, rate_exp});
    end
    $display("rate test done");
    wrr(`GWRD_REC_SLOT, 32'h0000_0005);
    rec(`GWRD_IDX_SDO_TMO, 12'h002, 32'h0000_0200, 8'h00);
    status(3'h1);
    wrr(`GWRD_CMD, 32'h0000_0002);
    nmt_exp(1'b1, 16'h0100);
    silent <= 1'b1;
    rec(`GWRD_IDX_SDO_DL, 12'h005, 32'h0134_1205, 8'h07);
    for (k = 0; k < 40; k++) begin
      rdr(`GWRD_STATUS, q);
      if (q[5]) break;
    end
    chk(32'(k >= 4 && k < 12), 32'h1);
    rdr(`GWRD_ABORT, q);
    chk(q, `GWRD_ABORT_TIMEOUT);
    wrr(`GWRD_CMD, 32'h0000_0004);
    silent <= 1'b0;
    rec(`GWRD_IDX_SDO_DL, 12'h008, 32'h0156_3406, 8'h07);
    @(negedge mclk_in);
    chk({sdo_node_out, sdo_index_out, sdo_subindex_out}, 32'h0634_5601);
    chk({12'h0, sdo_len_out, sdo_type_out}, 32'h0000_0307);
    for (i = 0; i < 3; i++) begin
      pay.push_back(8'($random(seed)));
      wrr(`GWRD_PAYLOAD, {24'h000000, pay[i]});
    end
    for (k = 0; k < 20; k++) begin
      rdr(`GWRD_STATUS, q);
      if (q[4:3] == 2'b00) break;
    end
    chk({26'h0, q[5:3]}, 32'h0);
    chk(32'(byteq.size()), 32'h3);
    foreach (pay[i]) chk({24'h0, byteq[i]}, {24'h0, pay[i]});
    rec(`GWRD_IDX_SDO_DL, 12'h005, 32'h0134_1200, 8'h07);
    status(3'h4);
    rec(`GWRD_IDX_SDO_DL, 12'h804, 32'h0134_1205, 8'h07);
    status(3'h3);
    $display("sdo test done");
    give_verdict();
  end
endmodule : gwrd_decoder_test
`default_nettype wire
